/* File: common/msw_map.svh */
// register offsets, field positions, codes and reset values of the status/wake block
`ifndef MSW_MAP_SVH
`define MSW_MAP_SVH

`define MSW_ADDR_W 8
`define MSW_OFF_STATUS 8'h30
`define MSW_OFF_WCTL 8'h40
`define MSW_OFF_IRQ_STS 8'h44
`define MSW_OFF_IRQ_MASK 8'h48

`define MSW_ST_PAUSE_SEND_PENDING 14
`define MSW_ST_PAUSING 13
`define MSW_ST_WAKE_HI 12
`define MSW_ST_WAKE_LO 10
`define MSW_ST_WAKE_LANE 1
`define MSW_ST_SPEED_HI 9
`define MSW_ST_SPEED_LO 7
`define MSW_ST_FDX 6

`define MSW_WC_LNK 9
`define MSW_WC_PAT 7
`define MSW_WC_FRM 5
`define MSW_WC_LNK_LANE 1
`define MSW_WC_LOW_LANE 0
`define MSW_WC_MODE_HI 2
`define MSW_WC_MODE_LO 0

`define MSW_WAKE_N 3
`define MSW_WK_PAT 2
`define MSW_WK_FRM 1
`define MSW_WK_LNK 0

`define MSW_IRQ_W 5
`define MSW_IRQ_PAUSE_SENT 3
`define MSW_IRQ_PAUSE_END 4

`define MSW_SPD_UNKNOWN 3'h0
`define MSW_SPD_10 3'h2
`define MSW_SPD_100 3'h3

`define MSW_QUANTA_W 16
`define MSW_QUANTA_ZERO 16'h0000
`define MSW_QUANTA_ONE 16'h0001
`define MSW_ARM_W 3
`define MSW_ARM_ZERO 3'h0
`define MSW_DATA_ZERO 32'h0000_0000
`define MSW_IRQ_ZERO 5'h00
`define MSW_MODE_ZERO 3'h0

`endif

/* File: common/msw_pkg.sv */
// types shared by the status/wake block
package msw_pkg;
	typedef logic [2:0] msw_speed_t;
	typedef logic [4:0] msw_irq_t;
	typedef logic [2:0] msw_wake_t;
	typedef logic [15:0] msw_quanta_t;
	typedef logic [31:0] msw_word_t;
endpackage

/* File: src/msw_status_wake.sv */
// controller status word, wake-cause latches, wake control and interrupt registers
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "msw_map.svh"

// Functional notes
// - status fields read only except wake latches
// - wake latches reset by power-on only
// - write one clears latch, zero keeps
// - reserved upper bits: write zero, read any
// - pause pending from command until sent
// - pausing from pause frame until timer expires
// - pattern latch set by match, mirrored
// - pattern latch cleared by control bit zero
// - frame latch set by match, mirrored
// - frame latch cleared by control bit zero
// - link latch set on link change, mirrored
// - link latch cleared by control bit one
// - speed field codes unknown, 10, 100
// - full duplex flag while full duplex
module msw_status_wake (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic por_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	input wire logic pause_cmd_accept,
	input wire logic pause_tx_done,
	input wire logic pause_frame_rx,
	input wire logic [15:0] pause_quanta,
	input wire logic pause_quantum_tick,
	input wire logic pattern_hit,
	input wire logic wakeup_frame_hit,
	input wire logic phy_link_status,
	input wire logic [2:0] speed_code,
	input wire logic full_duplex_in
);
	// bus slave
	logic waitreq_q, waitreq_d;
	msw_pkg::msw_word_t rdata_q, rdata_d;
	logic acc_wr;
	logic sel_status, sel_wctl, sel_ists, sel_imask;

	// live status
	logic pause_send_pending_q, pause_send_pending_d;
	logic pausing_q, pausing_d;
	msw_pkg::msw_quanta_t ptimer_q, ptimer_d;
	msw_pkg::msw_speed_t speed_q, speed_d;
	logic fdx_q, fdx_d;
	logic pause_sent, pause_end;

	// link change detection
	logic link_meta_q, link_sync_q, link_prev_q;
	logic [2:0] arm_q, arm_d;
	logic link_edge;

	// wake
	msw_pkg::msw_wake_t mode_q, mode_d;
	msw_pkg::msw_wake_t wake_set, wake_clr, wake_lat;

	// interrupts
	msw_pkg::msw_irq_t ists_q, ists_d, imask_q, imask_d;
	logic irq_q, irq_d;

	assign sel_status = (avs_address == `MSW_OFF_STATUS);
	assign sel_wctl = (avs_address == `MSW_OFF_WCTL);
	assign sel_ists = (avs_address == `MSW_OFF_IRQ_STS);
	assign sel_imask = (avs_address == `MSW_OFF_IRQ_MASK);
	// a write lands only on the edge where waitrequest is seen low
	assign acc_wr = avs_write && !waitreq_q;

	always_comb begin
		waitreq_d = !((avs_read || avs_write) && waitreq_q);
		rdata_d = rdata_q;
		if (avs_read && waitreq_q) begin
			rdata_d = `MSW_DATA_ZERO;
			if (sel_status) begin
				rdata_d[`MSW_ST_PAUSE_SEND_PENDING] = pause_send_pending_q;
				rdata_d[`MSW_ST_PAUSING] = pausing_q;
				rdata_d[`MSW_ST_WAKE_HI:`MSW_ST_WAKE_LO] = wake_lat;
				rdata_d[`MSW_ST_SPEED_HI:`MSW_ST_SPEED_LO] = speed_q;
				rdata_d[`MSW_ST_FDX] = fdx_q;
			end else if (sel_wctl) begin
				rdata_d[`MSW_WC_PAT] = wake_lat[`MSW_WK_PAT];
				rdata_d[`MSW_WC_FRM] = wake_lat[`MSW_WK_FRM];
				rdata_d[`MSW_WC_LNK] = wake_lat[`MSW_WK_LNK];
				rdata_d[`MSW_WC_MODE_HI:`MSW_WC_MODE_LO] = mode_q;
			end else if (sel_ists) begin
				rdata_d[`MSW_IRQ_W-1:0] = ists_q;
			end else if (sel_imask) begin
				rdata_d[`MSW_IRQ_W-1:0] = imask_q;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			waitreq_q <= 1'b1;
			rdata_q <= `MSW_DATA_ZERO;
		end else begin
			waitreq_q <= waitreq_d;
			rdata_q <= rdata_d;
		end
	end

	// pause state and live network status; bus writes never reach these
	always_comb begin
		pause_send_pending_d = pause_send_pending_q;
		if (pause_tx_done) begin
			pause_send_pending_d = 1'b0;
		end
		if (pause_cmd_accept) begin
			pause_send_pending_d = 1'b1;
		end
		ptimer_d = ptimer_q;
		if (pause_frame_rx) begin
			ptimer_d = pause_quanta;
		end else if (pause_quantum_tick && ptimer_q != `MSW_QUANTA_ZERO) begin
			ptimer_d = ptimer_q - `MSW_QUANTA_ONE;
		end
		pausing_d = (ptimer_d != `MSW_QUANTA_ZERO);
		unique case (speed_code)
			`MSW_SPD_10: speed_d = `MSW_SPD_10;
			`MSW_SPD_100: speed_d = `MSW_SPD_100;
			default: speed_d = `MSW_SPD_UNKNOWN;
		endcase
		fdx_d = full_duplex_in;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pause_send_pending_q <= 1'b0;
			ptimer_q <= `MSW_QUANTA_ZERO;
			pausing_q <= 1'b0;
			speed_q <= `MSW_SPD_UNKNOWN;
			fdx_q <= 1'b0;
		end else begin
			pause_send_pending_q <= pause_send_pending_d;
			ptimer_q <= ptimer_d;
			pausing_q <= pausing_d;
			speed_q <= speed_d;
			fdx_q <= fdx_d;
		end
	end

	assign pause_sent = pause_tx_done && pause_send_pending_q;
	assign pause_end = pausing_q && !pausing_d;

	// link pin synchroniser; arm_q masks the false edge while the pipe fills
	assign link_edge = arm_q[`MSW_ARM_W-1] && (link_sync_q != link_prev_q);

	always_comb begin
		arm_d = {arm_q[`MSW_ARM_W-2:0], 1'b1};
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			link_meta_q <= 1'b0;
			link_sync_q <= 1'b0;
			link_prev_q <= 1'b0;
			arm_q <= `MSW_ARM_ZERO;
		end else begin
			link_meta_q <= phy_link_status;
			link_sync_q <= link_meta_q;
			link_prev_q <= link_sync_q;
			arm_q <= arm_d;
		end
	end

	// wake mode enables survive bus reset like the latches
	always_comb begin
		mode_d = mode_q;
		if (acc_wr && sel_wctl && avs_byteenable[`MSW_WC_LOW_LANE]) begin
			mode_d = avs_writedata[`MSW_WC_MODE_HI:`MSW_WC_MODE_LO];
		end
		wake_set[`MSW_WK_PAT] = pattern_hit && mode_q[`MSW_WK_PAT];
		wake_set[`MSW_WK_FRM] = wakeup_frame_hit && mode_q[`MSW_WK_FRM];
		wake_set[`MSW_WK_LNK] = link_edge && mode_q[`MSW_WK_LNK];
		wake_clr = acc_wr && sel_status && avs_byteenable[`MSW_ST_WAKE_LANE]
			? avs_writedata[`MSW_ST_WAKE_HI:`MSW_ST_WAKE_LO] : `MSW_MODE_ZERO;
		if (acc_wr && sel_wctl) begin
			if (avs_byteenable[`MSW_WC_LOW_LANE] && !avs_writedata[`MSW_WC_PAT]) begin
				wake_clr[`MSW_WK_PAT] = 1'b1;
			end
			if (avs_byteenable[`MSW_WC_LOW_LANE] && !avs_writedata[`MSW_WC_FRM]) begin
				wake_clr[`MSW_WK_FRM] = 1'b1;
			end
			if (avs_byteenable[`MSW_WC_LNK_LANE] && avs_writedata[`MSW_WC_LNK]) begin
				wake_clr[`MSW_WK_LNK] = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge por_n) begin
		if (!por_n) begin
			mode_q <= `MSW_MODE_ZERO;
		end else begin
			mode_q <= mode_d;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `MSW_WAKE_N; gi++) begin : g_wake
			msw_wake_latch u_latch (
				.ref_clk(ref_clk),
				.por_n(por_n),
				.set_evt(wake_set[gi]),
				.clr_req(wake_clr[gi]),
				.latch(wake_lat[gi])
			);
		end
	endgenerate

	// interrupt status: write one to clear, a new event wins over the clear
	always_comb begin
		ists_d = ists_q;
		if (acc_wr && sel_ists && avs_byteenable[`MSW_WC_LOW_LANE]) begin
			ists_d = ists_q & ~avs_writedata[`MSW_IRQ_W-1:0];
		end
		ists_d = ists_d | {pause_end, pause_sent, wake_set};
		imask_d = imask_q;
		if (acc_wr && sel_imask && avs_byteenable[`MSW_WC_LOW_LANE]) begin
			imask_d = avs_writedata[`MSW_IRQ_W-1:0];
		end
		irq_d = |(ists_d & imask_d);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ists_q <= `MSW_IRQ_ZERO;
			imask_q <= `MSW_IRQ_ZERO;
			irq_q <= 1'b0;
		end else begin
			ists_q <= ists_d;
			imask_q <= imask_d;
			irq_q <= irq_d;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = waitreq_q;
	assign irq = irq_q;

	AST_STATUS_WRITE_IGNORED: assert property (@(posedge ref_clk) disable iff (!reset_n)
		acc_wr && sel_status && !pause_cmd_accept && !pause_tx_done |=> pause_send_pending_q == $past(pause_send_pending_q))
		else $error("status write changed the pause pending flag");

	AST_LATCH_HOLDS_IN_BUS_RESET: assert property (@(posedge ref_clk) disable iff (!por_n)
		!reset_n && wake_set == `MSW_MODE_ZERO |=> wake_lat == $past(wake_lat))
		else $error("wake latch disturbed by bus reset");

	AST_W1C_CLEARS: assert property (@(posedge ref_clk) disable iff (!reset_n || !por_n)
		acc_wr && sel_status && avs_byteenable[`MSW_ST_WAKE_LANE]
		&& avs_writedata[`MSW_ST_WAKE_HI] && !wake_set[`MSW_WK_PAT] |=> !wake_lat[`MSW_WK_PAT])
		else $error("write one did not clear the pattern latch");

	AST_W0_KEEPS: assert property (@(posedge ref_clk) disable iff (!reset_n || !por_n)
		acc_wr && sel_status && !avs_writedata[`MSW_ST_WAKE_LO] && wake_lat[`MSW_WK_LNK] |=> wake_lat[`MSW_WK_LNK])
		else $error("write zero cleared the link latch");

	AST_PAUSE_SEND_PENDING_SPAN: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pause_cmd_accept ##1 !pause_tx_done [*2] |-> pause_send_pending_q [*2])
		else $error("pause pending dropped before the frame was sent");

	AST_PAUSE_SEND_PENDING_END: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pause_tx_done && !pause_cmd_accept |=> !pause_send_pending_q)
		else $error("pause pending stuck after transmission");

	AST_PAUSING_TRACKS_TIMER: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pause_frame_rx && pause_quanta == `MSW_QUANTA_ONE ##1 pause_quantum_tick && !pause_frame_rx
		|-> pausing_q ##1 !pausing_q)
		else $error("pausing flag does not follow the pause timer");

	AST_WAKE_SET_WINS: assert property (@(posedge ref_clk) disable iff (!por_n)
		wake_set != `MSW_MODE_ZERO |=> (wake_lat & $past(wake_set)) == $past(wake_set))
		else $error("wake event lost against a clear");

	AST_WCTL_CLEARS: assert property (@(posedge ref_clk) disable iff (!reset_n || !por_n)
		acc_wr && sel_wctl && avs_byteenable == 4'hf && avs_writedata[`MSW_WC_LNK]
		&& !avs_writedata[`MSW_WC_PAT] && !avs_writedata[`MSW_WC_FRM] && wake_set == `MSW_MODE_ZERO
		|=> wake_lat == `MSW_MODE_ZERO)
		else $error("wake control write did not clear the latches");

	AST_LINK_EDGE_SETS: assert property (@(posedge ref_clk) disable iff (!reset_n || !por_n)
		mode_q[`MSW_WK_LNK] && arm_q[`MSW_ARM_W-1] && $changed(link_sync_q) |=> wake_lat[`MSW_WK_LNK])
		else $error("link change not latched");

	AST_SPEED_CODE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		speed_code == `MSW_SPD_100 ##1 speed_code == `MSW_SPD_100 |-> speed_q == `MSW_SPD_100 ##1 speed_q == `MSW_SPD_100)
		else $error("speed field does not report the link rate");

	AST_DUPLEX: assert property (@(posedge ref_clk) disable iff (!reset_n)
		full_duplex_in |=> fdx_q)
		else $error("full duplex flag not reported");

	AST_READ_STATUS: assert property (@(posedge ref_clk) disable iff (!reset_n)
		avs_read && waitreq_q && sel_status |=> !avs_waitrequest
		&& avs_readdata[`MSW_ST_SPEED_HI:`MSW_ST_SPEED_LO] == $past(speed_q))
		else $error("status read returned wrong speed or no answer");
endmodule
`default_nettype wire

/* File: src/msw_wake_latch.sv */
// one power-on-reset sticky wake-cause latch
`timescale 1ns/1ps
`default_nettype none
module msw_wake_latch (
	input wire logic ref_clk,
	input wire logic por_n,
	input wire logic set_evt,
	input wire logic clr_req,
	output logic latch
);
	logic latch_q;
	logic latch_d;

	always_comb begin
		latch_d = latch_q;
		if (clr_req) begin
			latch_d = 1'b0;
		end
		if (set_evt) begin
			latch_d = 1'b1;
		end
	end

	// only power-on reset touches the latch, the bus reset does not
	always_ff @(posedge ref_clk or negedge por_n) begin
		if (!por_n) begin
			latch_q <= 1'b0;
		end else begin
			latch_q <= latch_d;
		end
	end

	assign latch = latch_q;
endmodule
`default_nettype wire

/* File: test/msw_net_model.sv */
// network-side event and level source for the status/wake block
`timescale 1ns/1ps
`default_nettype none
module msw_net_model (
	input wire logic ref_clk,
	output logic pause_cmd_accept,
	output logic pause_tx_done,
	output logic pause_frame_rx,
	output logic [15:0] pause_quanta,
	output logic pause_quantum_tick,
	output logic pattern_hit,
	output logic wakeup_frame_hit,
	output logic phy_link_status,
	output logic [2:0] speed_code,
	output logic full_duplex_in
);
	logic [5:0] ev = 6'h00;
	assign {wakeup_frame_hit, pattern_hit, pause_quantum_tick, pause_frame_rx, pause_tx_done, pause_cmd_accept} = ev;
	initial begin
		pause_quanta = 16'hffff;
		phy_link_status = 1'b0;
		speed_code = 3'h0;
		full_duplex_in = 1'b0;
	end
	// one-cycle event pulses; quanta only meaningful with the receive pulse
	task automatic pulse(input logic [5:0] m, input logic [15:0] q);
		@(posedge ref_clk);
		ev <= m;
		pause_quanta <= q;
		@(posedge ref_clk);
		ev <= 6'h00;
		pause_quanta <= ~q;
	endtask
	// two back-to-back event cycles, quanta given with the first
	task automatic pulse2(input logic [5:0] m1, input logic [15:0] q, input logic [5:0] m2);
		@(posedge ref_clk);
		ev <= m1;
		pause_quanta <= q;
		@(posedge ref_clk);
		ev <= m2;
		pause_quanta <= ~q;
		@(posedge ref_clk);
		ev <= 6'h00;
	endtask
	task automatic levels(input logic [2:0] spd, input logic fdx, input logic lnk);
		@(posedge ref_clk);
		speed_code <= spd;
		full_duplex_in <= fdx;
		phy_link_status <= lnk;
	endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the status/wake register block
`timescale 1ns/1ps
`default_nettype none
`include "msw_map.svh"
module tb;
	localparam logic [7:0] a_st = `MSW_OFF_STATUS;
	localparam logic [7:0] a_wc = `MSW_OFF_WCTL;
	localparam logic [7:0] a_is = `MSW_OFF_IRQ_STS;
	localparam logic [7:0] a_im = `MSW_OFF_IRQ_MASK;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic por_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	wire logic p_acc, p_done, p_rx, p_tick, pat, frm, lnk, fdx;
	wire logic [15:0] quanta;
	wire logic [2:0] spd;
	int mismatches = 0;
	int comparisons = 0;
	int cyc = 0;
	always #5 ref_clk = ~ref_clk;
	msw_net_model i_msw_net_model (.ref_clk(ref_clk), .pause_cmd_accept(p_acc), .pause_tx_done(p_done),
		.pause_frame_rx(p_rx), .pause_quanta(quanta), .pause_quantum_tick(p_tick), .pattern_hit(pat),
		.wakeup_frame_hit(frm), .phy_link_status(lnk), .speed_code(spd), .full_duplex_in(fdx));
	msw_status_wake i_msw_status_wake (.ref_clk(ref_clk), .reset_n(reset_n), .por_n(por_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.pause_cmd_accept(p_acc), .pause_tx_done(p_done), .pause_frame_rx(p_rx), .pause_quanta(quanta),
		.pause_quantum_tick(p_tick), .pattern_hit(pat), .wakeup_frame_hit(frm), .phy_link_status(lnk),
		.speed_code(spd), .full_duplex_in(fdx));
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			$display("wrong value at %0t: timeout", $time);
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// hold the request until waitrequest is seen low, release after that edge
	task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= is_wr;
		avs_read <= !is_wr;
		avs_writedata <= d;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		por_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rd(a_st, 32'h0000_0000);
		rd(8'h10, 32'h0000_0000);
		for (int i = 0; i < 8; i++) begin
			i_msw_net_model.levels(i[2:0], i[0], 1'b0);
			rd(a_st, {22'h0, ((i == 2 || i == 3) ? i[2:0] : 3'h0), i[0], 6'h00});
		end
		i_msw_net_model.levels(3'h3, 1'b1, 1'b0);
		wr(a_st, 32'h0000_63c0);
		rd(a_st, 32'h0000_01c0);
		$display("read-only fields test done");
		i_msw_net_model.pulse(6'h01, 16'h0000);
		rd(a_st, 32'h0000_41c0);
		i_msw_net_model.pulse(6'h02, 16'h0000);
		rd(a_st, 32'h0000_01c0);
		i_msw_net_model.pulse(6'h04, 16'h0002);
		rd(a_st, 32'h0000_21c0);
		i_msw_net_model.pulse(6'h08, 16'h0000);
		rd(a_st, 32'h0000_21c0);
		i_msw_net_model.pulse(6'h08, 16'h0000);
		rd(a_st, 32'h0000_01c0);
		i_msw_net_model.pulse2(6'h04, 16'h0001, 6'h08);
		rd(a_st, 32'h0000_01c0);
		$display("pause test done");
		wr(a_wc, 32'h0000_00a7);
		wr(a_im, 32'h0000_0004);
		i_msw_net_model.pulse(6'h10, 16'h0000);
		rd(a_st, 32'h0000_11c0);
		chk({31'h0, irq}, 32'h0000_0001);
		rd(a_wc, 32'h0000_0087);
		i_msw_net_model.pulse(6'h20, 16'h0000);
		i_msw_net_model.levels(3'h3, 1'b1, 1'b1);
		repeat (8) @(posedge ref_clk);
		rd(a_st, 32'h0000_1dc0);
		rd(a_wc, 32'h0000_02a7);
		wr(a_st, 32'h0000_1000);
		rd(a_st, 32'h0000_0dc0);
		wr(a_wc, 32'h0000_0087);
		rd(a_st, 32'h0000_05c0);
		wr(a_wc, 32'h0000_02a7);
		rd(a_st, 32'h0000_01c0);
		rd(a_is, 32'h0000_001f);
		wr(a_is, 32'h0000_001f);
		rd(a_is, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
		i_msw_net_model.pulse(6'h10, 16'h0000);
		wr(a_wc, 32'h0000_0027);
		rd(a_st, 32'h0000_01c0);
		i_msw_net_model.pulse(6'h30, 16'h0000);
		rd(a_st, 32'h0000_19c0);
		wr(a_wc, 32'h0000_0207);
		rd(a_st, 32'h0000_01c0);
		$display("wake latch test done");
		fork
			wr(a_st, 32'h0000_1000);
			begin
				@(posedge ref_clk);
				i_msw_net_model.pulse(6'h10, 16'h0000);
			end
		join
		rd(a_st, 32'h0000_11c0);
		avs_byteenable <= 4'h1;
		wr(a_st, 32'h0000_1000);
		rd(a_st, 32'h0000_11c0);
		avs_byteenable <= 4'hf;
		i_msw_net_model.pulse(6'h01, 16'h0000);
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rd(a_st, 32'h0000_11c0);
		@(posedge ref_clk);
		por_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		por_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rd(a_st, 32'h0000_01c0);
		i_msw_net_model.pulse(6'h10, 16'h0000);
		rd(a_st, 32'h0000_01c0);
		$display("reset test done");
		test_done();
	end
endmodule
`default_nettype wire
